// file: verilog/cbmb_core.sv
// Execution core for branches, moves, shifts and flag/bit operations.
// Assumes an external decoder presents one operation at a time with valid/ready,
// and a data/I-O space that answers reads in the same cycle as the read strobe.
//
// What this block does
// - Branch when selected status bit is zero
// - Carry clear/set branches, flags untouched
// - Unsigned same-or-higher/lower branch on carry
// - Signed greater-or-equal when N xor V zero
// - Signed less-than when N xor V one
// - Half-carry set/clear branches
// - T flag set/clear branches
// - Overflow set/clear branches
// - Branch when global interrupt enable set
// - Load Rd from Z address, two clocks
// - Store Rr to Z address, two clocks
// - Copy, immediate, port moves in one clock
// - Set I/O bit, two clocks
// - Clear I/O bit, two clocks
// - Rotate/shift left, updates Z C N V
// - Rotate/shift right, updates Z C N V
// - Arithmetic right shift keeps bit 7
// - Copy register bit into T
// - Copy T into register bit
// - Interrupt enable set and clear
// - Force any single status flag
`timescale 1ns/100ps
module cbmb_core
  import cbmb_pkg::*;
#(
  parameter int unsigned PCW = 12,
  parameter int unsigned KW = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Decoded operation
  input wire logic op_valid_i,
  output logic op_ready_o,
  input wire logic [4:0] op_code_i,
  input wire logic [REG_AW-1:0] op_rd_i,
  input wire logic [REG_AW-1:0] op_rr_i,
  input wire logic [2:0] op_bit_i,
  input wire logic [KW-1:0] op_k_i,
  input wire logic [7:0] op_imm_i,
  input wire logic [5:0] op_port_i,
  // Data and I/O space
  output logic mem_re_o,
  output logic mem_we_o,
  output logic mem_io_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // Status
  output logic [PCW-1:0] pc_o,
  output logic [7:0] flags_o,
  output logic busy_o
);
  cbmb_state_t st_q, st_d;
  logic [PCW-1:0] pc_q, pc_d;
  logic [7:0] fl_q, fl_d;
  logic [4:0] code_q, code_d;
  logic [REG_AW-1:0] rd_q, rd_d;
  logic [2:0] bit_q, bit_d;
  logic [5:0] port_q, port_d;
  logic [PCW-1:0] tgt_q, tgt_d;
  logic re_q, re_d, we_q, we_d, io_q, io_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d;
  logic rf_we;
  logic [REG_AW-1:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic [7:0] ra, rb;
  logic [15:0] zptr;
  logic take;
  logic [7:0] sh;
  logic sh_c;
  logic [PCW-1:0] pc_inc;
  logic [PCW-1:0] koff;
  // Pending port write meets a new memory op
  logic out_clash;

  // Operands are read a cycle late, as the register file registers them first
  cbmb_regfile #(.DW(8)) u_rf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(rf_we),
    .waddr_i(rf_waddr),
    .wdata_i(rf_wdata),
    .raddr_a_i(op_rd_i),
    .raddr_b_i(op_rr_i),
    .rdata_a_o(ra),
    .rdata_b_o(rb),
    .zptr_o(zptr)
  );

  // Branch condition on one status bit
  function automatic logic flag_test(input logic [7:0] f, input logic [2:0] s,
                                     input logic want);
    flag_test = (f[s] == want);
  endfunction

  // Bit mask from bit number, used by I/O and T-bit paths
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  // Ready only in the issue state; the second cycle stalls the decoder
  // The port write lands a clock late, so a memory op behind it waits one clock
  assign out_clash = (cbmb_op_t'(code_q) == OP_PORT_OUT)
                     && (cbmb_op_t'(op_code_i) inside {OP_LOAD_Z, OP_STORE_Z, OP_PORT_IN,
                                                       OP_IO_SET, OP_IO_CLR});
  assign op_ready_o = (st_q == ST_EXEC) && !out_clash;
  assign busy_o = (st_q != ST_EXEC);
  assign pc_inc = pc_q + {{(PCW-1){1'b0}}, 1'b1};
  assign koff = PCW'(signed'(op_k_i));

  // Shift and rotate unit on the operand held from the register file
  always_comb begin
    sh = ra;
    sh_c = fl_q[FLAG_C];
    unique case (cbmb_op_t'(code_q))
      OP_LSL: begin
        sh = {ra[6:0], 1'b0};
        sh_c = ra[7];
      end
      OP_ROL: begin
        sh = {ra[6:0], fl_q[FLAG_C]};
        sh_c = ra[7];
      end
      OP_LSR: begin
        sh = {1'b0, ra[7:1]};
        sh_c = ra[0];
      end
      OP_ROR: begin
        sh = {fl_q[FLAG_C], ra[7:1]};
        sh_c = ra[0];
      end
      OP_ASR: begin
        sh = {ra[7], ra[7:1]};
        sh_c = ra[0];
      end
      default: begin
        sh = ra;
        sh_c = fl_q[FLAG_C];
      end
    endcase
  end

  // Issue decode: branch conditions evaluated against current flags
  // Flags a shift or bit store writes at this same edge are not yet seen;
  // the decoder keeps one op between such a write and a branch on it
  always_comb begin
    take = 1'b0;
    unique case (cbmb_op_t'(op_code_i))
      // Covers carry, unsigned, half-carry, T, overflow, I variants
      OP_BR_CLEAR: take = flag_test(fl_q, op_bit_i, 1'b0);
      OP_BR_SET: take = flag_test(fl_q, op_bit_i, 1'b1);
      OP_BR_GE: take = ~(fl_q[FLAG_N] ^ fl_q[FLAG_V]);
      OP_BR_LT: take = fl_q[FLAG_N] ^ fl_q[FLAG_V];
      default: take = 1'b0;
    endcase
  end

  // Sequencer, program counter, flags and memory strobes
  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    fl_d = fl_q;
    code_d = code_q;
    rd_d = rd_q;
    bit_d = bit_q;
    port_d = port_q;
    tgt_d = tgt_q;
    re_d = 1'b0;
    we_d = 1'b0;
    io_d = 1'b0;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rf_we = 1'b0;
    rf_waddr = rd_q;
    rf_wdata = sh;
    unique case (st_q)
      ST_EXEC: begin
        // Complete the one-clock operation issued last cycle
        unique case (cbmb_op_t'(code_q))
          OP_LSL, OP_ROL, OP_LSR, OP_ROR, OP_ASR: begin
            rf_we = 1'b1;
            fl_d[FLAG_C] = sh_c;
            fl_d[FLAG_Z] = (sh == 8'h00);
            fl_d[FLAG_N] = sh[7];
            fl_d[FLAG_V] = sh[7] ^ sh_c;
          end
          OP_COPY: begin
            rf_we = 1'b1;
            rf_wdata = rb;
          end
          OP_LOAD_IMM: begin
            rf_we = 1'b1;
            rf_wdata = wdat_q;
          end
          OP_PORT_IN, OP_LOAD_Z: begin
            rf_we = 1'b1;
            rf_wdata = mem_rdata_i;
          end
          OP_BIT_TO_T: fl_d[FLAG_T] = rb[bit_q];
          OP_T_TO_BIT: begin
            rf_we = 1'b1;
            rf_wdata = fl_q[FLAG_T] ? (ra | bit_mask(bit_q))
                                    : (ra & ~bit_mask(bit_q));
          end
          OP_STORE_Z, OP_PORT_OUT: begin
            we_d = 1'b0;
          end
          default: rf_we = 1'b0;
        endcase
        code_d = 5'(OP_NOP);
        // Issue a new operation; the PC steps at the same edge
        if (op_valid_i && !out_clash) begin
          code_d = op_code_i;
          rd_d = op_rd_i;
          bit_d = op_bit_i;
          port_d = op_port_i;
          wdat_d = op_imm_i;
          pc_d = pc_inc;
          unique case (cbmb_op_t'(op_code_i))
            OP_BR_CLEAR, OP_BR_SET, OP_BR_GE, OP_BR_LT: begin
              if (take) begin
                tgt_d = pc_inc + koff;
                st_d = ST_SECOND;
              end
            end
            OP_LOAD_Z: begin
              re_d = 1'b1;
              addr_d = zptr;
              st_d = ST_SECOND;
            end
            OP_STORE_Z: begin
              st_d = ST_SECOND;
            end
            OP_PORT_IN, OP_IO_SET, OP_IO_CLR: begin
              re_d = 1'b1;
              io_d = 1'b1;
              addr_d = {10'h000, op_port_i};
              if (cbmb_op_t'(op_code_i) != OP_PORT_IN) begin
                st_d = ST_SECOND;
              end
            end
            OP_PORT_OUT: begin
              st_d = ST_EXEC;
            end
            OP_FLAG_SET: fl_d[op_bit_i] = 1'b1;
            OP_FLAG_CLR: fl_d[op_bit_i] = 1'b0;
            default: st_d = ST_EXEC;
          endcase
        end
      end
      ST_SECOND: begin
        // Second clock: PC reload, load write-back, store or modify-write
        st_d = ST_EXEC;
        code_d = 5'(OP_NOP);
        unique case (cbmb_op_t'(code_q))
          OP_BR_CLEAR, OP_BR_SET, OP_BR_GE, OP_BR_LT: begin
            pc_d = tgt_q;
          end
          OP_LOAD_Z: begin
            rf_we = 1'b1;
            rf_wdata = mem_rdata_i;
          end
          OP_STORE_Z: begin
            we_d = 1'b1;
            addr_d = zptr;
            wdat_d = rb;
          end
          OP_IO_SET: begin
            we_d = 1'b1;
            io_d = 1'b1;
            wdat_d = mem_rdata_i | bit_mask(bit_q);
          end
          OP_IO_CLR: begin
            we_d = 1'b1;
            io_d = 1'b1;
            wdat_d = mem_rdata_i & ~bit_mask(bit_q);
          end
          default: st_d = ST_EXEC;
        endcase
      end
      default: st_d = ST_EXEC;
    endcase
    // Port write uses the register read one cycle after issue
    // It overlaps the next issue, hence the out_clash hold-off above
    if (st_q == ST_EXEC && cbmb_op_t'(code_q) == OP_PORT_OUT) begin
      we_d = 1'b1;
      io_d = 1'b1;
      addr_d = {10'h000, port_q};
      wdat_d = rb;
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_EXEC;
      pc_q <= PC_RST[PCW-1:0];
      fl_q <= FLAGS_RST;
      code_q <= 5'h00;
      rd_q <= '0;
      bit_q <= 3'h0;
      port_q <= 6'h00;
      tgt_q <= '0;
      re_q <= 1'b0;
      we_q <= 1'b0;
      io_q <= 1'b0;
      addr_q <= 16'h0000;
      wdat_q <= 8'h00;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      fl_q <= fl_d;
      code_q <= code_d;
      rd_q <= rd_d;
      bit_q <= bit_d;
      port_q <= port_d;
      tgt_q <= tgt_d;
      re_q <= re_d;
      we_q <= we_d;
      io_q <= io_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
    end
  end

  // Bus and status outputs straight from registers
  assign mem_re_o = re_q;
  assign mem_we_o = we_q;
  assign mem_io_o = io_q;
  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdat_q;
  assign pc_o = pc_q;
  assign flags_o = fl_q;
endmodule // cbmb_core

// file: verilog/cbmb_pkg.sv
// Package for the branch, move and bit-operation execution core.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
package cbmb_pkg;
  // Status flag bit positions
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [7:0] REG_RST = 8'h00;
  // Register file geometry
  localparam int unsigned REG_CNT = 32;
  localparam int unsigned REG_AW = 5;
  // Timing counts in clocks
  localparam int unsigned CYC_BRANCH_TAKEN = 2;
  localparam int unsigned CYC_MEM_ACCESS = 2;
  localparam int unsigned CYC_SINGLE = 1;
  // Z pointer registers
  localparam logic [4:0] ZL_IDX = 5'h1e;
  localparam logic [4:0] ZH_IDX = 5'h1f;

  // Operation codes presented on the decoded-instruction port
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_BR_CLEAR = 5'h01, // branch when selected flag is 0
    OP_BR_SET = 5'h02, // branch when selected flag is 1
    OP_BR_GE = 5'h03,
    OP_BR_LT = 5'h04,
    OP_LOAD_Z = 5'h05,
    OP_STORE_Z = 5'h06,
    OP_COPY = 5'h07,
    OP_LOAD_IMM = 5'h08,
    OP_PORT_IN = 5'h09,
    OP_PORT_OUT = 5'h0a,
    OP_IO_SET = 5'h0b,
    OP_IO_CLR = 5'h0c,
    OP_LSL = 5'h0d,
    OP_LSR = 5'h0e,
    OP_ROL = 5'h0f,
    OP_ROR = 5'h10,
    OP_ASR = 5'h11,
    OP_BIT_TO_T = 5'h12,
    OP_T_TO_BIT = 5'h13,
    OP_FLAG_SET = 5'h14,
    OP_FLAG_CLR = 5'h15
  } cbmb_op_t;

  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_SECOND = 2'b01
  } cbmb_state_t;
endpackage

// file: verilog/cbmb_regfile.sv
// Working register file with registered read ports.
// Assumes the core gives at most one write per clock.
`timescale 1ns/100ps
module cbmb_regfile
  import cbmb_pkg::*;
#(
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic we_i,
  input wire logic [REG_AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read ports
  input wire logic [REG_AW-1:0] raddr_a_i,
  input wire logic [REG_AW-1:0] raddr_b_i,
  output logic [DW-1:0] rdata_a_o,
  output logic [DW-1:0] rdata_b_o,
  // Z pointer, always visible
  output logic [2*DW-1:0] zptr_o
);
  logic [DW-1:0] mem_q [REG_CNT];
  logic [DW-1:0] mem_d [REG_CNT];
  logic [DW-1:0] ra_d;
  logic [DW-1:0] ra_q;
  logic [DW-1:0] rb_d;
  logic [DW-1:0] rb_q;

  // Next state of storage; write bypass keeps reads coherent
  always_comb begin
    for (int i = 0; i < REG_CNT; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (we_i) begin
      mem_d[waddr_i] = wdata_i;
    end
    ra_d = mem_d[raddr_a_i];
    rb_d = mem_d[raddr_b_i];
  end

  // Storage and read registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < REG_CNT; i++) begin
        mem_q[i] <= REG_RST;
      end
      ra_q <= REG_RST;
      rb_q <= REG_RST;
    end else begin
      for (int i = 0; i < REG_CNT; i++) begin
        mem_q[i] <= mem_d[i];
      end
      ra_q <= ra_d;
      rb_q <= rb_d;
    end
  end

  assign rdata_a_o = ra_q;
  assign rdata_b_o = rb_q;
  assign zptr_o = {mem_q[ZH_IDX], mem_q[ZL_IDX]};
endmodule // cbmb_regfile

// file: verif/cbmb_mem_model.sv
// Data and I/O space model on the far side of the core's memory port.
// Assumes one access a cycle; reads answered at once and held one cycle.
`timescale 1ns/100ps
module cbmb_mem_model (
  // Clock
  input wire logic clk_i,
  // Access from the core
  input wire logic re_i,
  input wire logic we_i,
  input wire logic io_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] dmem [256];
  logic [7:0] iomem [32];
  logic [7:0] last_q = 8'h00;
  logic hold_q = 1'b0;
  logic [7:0] cur;
  // I/O indexed by low five bits, so an I/O base offset that is a multiple of 32 still lands
  assign cur = io_i ? iomem[addr_i[4:0]] : dmem[addr_i[7:0]];
  // Stale data inverted so a late sample cannot match by luck
  assign rdata_o = re_i ? cur : (hold_q ? last_q : ~last_q);
  // Registered write and read hold
  always @(posedge clk_i) begin
    hold_q <= re_i;
    if (re_i) last_q <= cur;
    if (we_i && io_i) iomem[addr_i[4:0]] <= wdata_i;
    else if (we_i) dmem[addr_i[7:0]] <= wdata_i;
  end
endmodule // cbmb_mem_model

// file: verif/cbmb_core_monitor.sv
// Port-level checker for the execution core.
// Assumes the bind below reaches every core instance.
`timescale 1ns/100ps
module cbmb_core_chk
  import cbmb_pkg::*;
#(
  parameter int unsigned PCW = 12,
  parameter int unsigned KW = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Operation
  input wire logic op_valid_i,
  input wire logic op_ready_o,
  input wire logic [4:0] op_code_i,
  input wire logic [2:0] op_bit_i,
  input wire logic [KW-1:0] op_k_i,
  // Memory and status
  input wire logic mem_re_o,
  input wire logic mem_we_o,
  input wire logic mem_io_o,
  input wire logic [PCW-1:0] pc_o,
  input wire logic [7:0] flags_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [PCW-1:0] k_ext;
  logic tk, nv, fb, is_br, fall;
  // Decoded conditions seen at the issue edge
  assign k_ext = {{(PCW-KW){op_k_i[KW-1]}}, op_k_i};
  assign tk = op_valid_i && op_ready_o;
  assign nv = flags_o[FLAG_N] ^ flags_o[FLAG_V];
  assign fb = flags_o[op_bit_i];
  assign is_br = op_code_i inside {OP_BR_CLEAR, OP_BR_SET, OP_BR_GE, OP_BR_LT};
  assign fall = (op_code_i == OP_BR_CLEAR && fb) || (op_code_i == OP_BR_SET && !fb)
    || (op_code_i == OP_BR_GE && nv) || (op_code_i == OP_BR_LT && !nv);
  // Taken branch: one stall cycle, then the target
  sequence s_jump;
    !op_ready_o && pc_o == $past(pc_o) + 1'b1 ##1
    op_ready_o && pc_o == $past(pc_o, 2) + 1'b1 + $past(k_ext, 2);
  endsequence
  // Read-modify-write on the I/O space
  sequence s_rmw;
    mem_re_o && mem_io_o ##1 mem_we_o && mem_io_o && !mem_re_o;
  endsequence
  chk_br_clear_jump: assert property (tk && op_code_i == OP_BR_CLEAR && !fb |=> s_jump)
    else $error("clear-sense branch did not jump");
  chk_br_set_jump: assert property (tk && op_code_i == OP_BR_SET && fb |=> s_jump)
    else $error("set-sense branch did not jump");
  chk_br_ge_jump: assert property (tk && op_code_i == OP_BR_GE && !nv |=> s_jump)
    else $error("signed ge branch did not jump");
  chk_br_lt_jump: assert property (tk && op_code_i == OP_BR_LT && nv |=> s_jump)
    else $error("signed lt branch did not jump");
  chk_br_fall_thru: assert property (tk && fall |=> op_ready_o && pc_o == $past(pc_o) + 1'b1)
    else $error("untaken branch not one clock");
  chk_br_flags_kept: assert property (tk && is_br |=> $stable(flags_o))
    else $error("branch changed flags");
  chk_flag_force: assert property (tk && op_code_i inside {OP_FLAG_SET, OP_FLAG_CLR} |=>
    flags_o[$past(op_bit_i)] == ($past(op_code_i) == OP_FLAG_SET))
    else $error("flag not forced");
  chk_load_read: assert property (tk && op_code_i == OP_LOAD_Z |=> mem_re_o && !mem_io_o && busy_o)
    else $error("indirect load read missing");
  chk_store_write: assert property (tk && op_code_i == OP_STORE_Z |=>
    busy_o && !mem_we_o ##1 mem_we_o && !mem_io_o)
    else $error("indirect store write missing");
  chk_io_rmw: assert property (tk && op_code_i inside {OP_IO_SET, OP_IO_CLR} |=> s_rmw)
    else $error("io bit op not read then write");
  chk_one_clock: assert property (tk && op_code_i inside {OP_COPY, OP_LOAD_IMM, OP_LSL, OP_LSR,
    OP_ROL, OP_ROR, OP_ASR, OP_BIT_TO_T, OP_T_TO_BIT} |=> op_ready_o && !busy_o)
    else $error("single-clock op stalled");
endmodule // cbmb_core_chk

bind cbmb_core cbmb_core_chk #(.PCW(PCW), .KW(KW)) chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .op_code_i(op_code_i),
  .op_bit_i(op_bit_i), .op_k_i(op_k_i), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
  .mem_io_o(mem_io_o), .pc_o(pc_o), .flags_o(flags_o), .busy_o(busy_o));

// file: verif/cpu_branch_move_bit_ops_tb_top.sv
// Self-checking bench for the execution core and its memory model.
// Assumes the core takes an operation on valid and ready at a rising edge.
`timescale 1ns/100ps
module cpu_branch_move_bit_ops_tb_top;
  import cbmb_pkg::*;
  logic clk_i, rst_n_i, op_valid_i, op_ready_o, mem_re_o, mem_we_o, mem_io_o, busy_o;
  logic [4:0] op_code_i, op_rd_i, op_rr_i;
  logic [2:0] op_bit_i;
  logic [6:0] op_k_i;
  logic [7:0] op_imm_i, mem_wdata_o, mem_rdata_i, flags_o, ef;
  logic [5:0] op_port_i;
  logic [15:0] mem_addr_o;
  logic [11:0] pc_o, epc;
  int n_errors, num_checks, cyc;
  // Shift table: result and V N Z C from 8'h80 with carry in set
  cbmb_op_t sh [5] = '{OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR};
  logic [7:0] sr [5] = '{8'h00, 8'h40, 8'h01, 8'hc0, 8'hc0};
  logic [3:0] sf [5] = '{4'hb, 4'h0, 4'h9, 4'hc, 4'hc};
  cbmb_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
    .op_ready_o(op_ready_o), .op_code_i(op_code_i), .op_rd_i(op_rd_i), .op_rr_i(op_rr_i),
    .op_bit_i(op_bit_i), .op_k_i(op_k_i), .op_imm_i(op_imm_i), .op_port_i(op_port_i),
    .mem_re_o(mem_re_o), .mem_we_o(mem_we_o), .mem_io_o(mem_io_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .pc_o(pc_o), .flags_o(flags_o),
    .busy_o(busy_o));
  cbmb_mem_model mem_u (.clk_i(clk_i), .re_i(mem_re_o), .we_i(mem_we_o), .io_i(mem_io_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  // Clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Offer one op; valid stays up between back-to-back calls, each call driving it and all fields again
  task automatic op(cbmb_op_t c, logic [4:0] rd, logic [4:0] rr, logic [2:0] b,
                    logic [7:0] v, logic [5:0] p);
    logic r;
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_rd_i <= rd;
    op_rr_i <= rr;
    op_bit_i <= b;
    op_k_i <= v[6:0];
    op_imm_i <= v;
    op_port_i <= p;
    epc = epc + 1'b1;
    do begin
      @(negedge clk_i) r = op_ready_o;
      @(posedge clk_i);
    end while (r !== 1'b1);
  endtask
  task automatic quiet(int n);
    op_valid_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  task automatic fl(logic [2:0] s, logic v);
    op(v ? OP_FLAG_SET : OP_FLAG_CLR, 0, 0, s, 0, 0);
    ef[s] = v;
  endtask
  task automatic ld(logic [4:0] r, logic [7:0] v);
    op(OP_LOAD_IMM, r, 0, 0, v, 0);
  endtask
  // Branch with expected target from the bench's own flag copy
  task automatic br(cbmb_op_t c, logic [2:0] s, logic [6:0] k);
    logic t;
    t = (c == OP_BR_CLEAR) ? !ef[s] : (c == OP_BR_SET) ? ef[s] :
        ((ef[FLAG_N] ^ ef[FLAG_V]) == (c == OP_BR_LT));
    op(c, 0, 0, s, {1'b0, k}, 0);
    if (t) epc = epc + {{5{k[6]}}, k};
  endtask
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    op_valid_i = 1'b0;
    {op_code_i, op_rd_i, op_rr_i, op_bit_i, op_k_i, op_imm_i, op_port_i} = '0;
    epc = PC_RST;
    ef = FLAGS_RST;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    cmp("pc", PC_RST, pc_o);
    cmp("flags", FLAGS_RST, flags_o);
    cmp("ready", 1'b1, op_ready_o);
    @(posedge clk_i) rst_n_i <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 2; v++) begin
        fl(3'(s), v[0]);
        quiet(2);
        cmp("flags", ef, flags_o);
        br(OP_BR_CLEAR, 3'(s), 7'h05);
        br(OP_BR_SET, 3'(s), 7'h7d);
        quiet(3);
        cmp("pc", epc, pc_o);
      end
    end
    for (int i = 0; i < 4; i++) begin
      fl(FLAG_N, i[1]);
      fl(FLAG_V, i[0]);
      quiet(2);
      br(OP_BR_GE, 0, 7'h03);
      br(OP_BR_LT, 0, 7'h7f);
      quiet(3);
      cmp("pc", epc, pc_o);
    end
    // Z pointer, moves and I/O bit ops, back to back
    ld(5'h1e, 8'h34);
    ld(5'h1f, 8'h12);
    ld(5'h05, 8'ha5);
    op(OP_STORE_Z, 0, 5, 0, 0, 0);
    op(OP_LOAD_Z, 6, 0, 0, 0, 0);
    op(OP_COPY, 7, 6, 0, 0, 0);
    op(OP_PORT_OUT, 0, 7, 0, 0, 6'h04);
    op(OP_IO_CLR, 0, 0, 0, 0, 6'h04);
    op(OP_IO_SET, 0, 0, 1, 0, 6'h04);
    op(OP_PORT_IN, 8, 0, 0, 0, 6'h04);
    op(OP_PORT_OUT, 0, 8, 0, 0, 6'h05);
    quiet(3);
    cmp("dmem", 8'ha5, mem_u.dmem[8'h34]);
    cmp("io", 8'ha6, mem_u.iomem[5]);
    cmp("flags", ef, flags_o);
    foreach (sh[i]) begin
      ld(5'h09, 8'h80);
      fl(FLAG_C, 1'b1);
      op(sh[i], 9, 9, 0, 0, 0);
      op(OP_PORT_OUT, 0, 9, 0, 0, 6'h06);
      quiet(3);
      ef[3:0] = sf[i];
      cmp("shift", sr[i], mem_u.iomem[6]);
      cmp("flags", ef, flags_o);
    end
    // T flag in and out of a register
    ld(5'h0a, 8'h20);
    fl(FLAG_T, 1'b0);
    op(OP_BIT_TO_T, 10, 10, 5, 0, 0);
    op(OP_T_TO_BIT, 10, 10, 0, 0, 0);
    op(OP_PORT_OUT, 0, 10, 0, 0, 6'h07);
    quiet(3);
    ef[FLAG_T] = 1'b1;
    cmp("tbit", 8'h21, mem_u.iomem[7]);
    cmp("flags", ef, flags_o);
    cmp("pc", epc, pc_o);
    stop_test();
  end
endmodule // cpu_branch_move_bit_ops_tb_top
